// file: rtl/sar_adc_pkg.sv
// Function
// [R01] With sample-and-hold: 33 cycles at 10 bits, 28 at 8 bits.
// [R02] Without sample-and-hold: 59 cycles at 10 bits, 49 at 8 bits.
// [R03] Cycle count applies once per converted channel.
// [R04] Conversion clock is source divided by 4, by 2, or undivided.
// [R05] Sample-and-hold samples input for 3 cycles, then converts.
// [R06] Software keeps conversion clock at 1 MHz or more with hold.
// [R07] 8-bit resolution resolves only the top 8 of 10 bits.
// [R08] A setting selects software start or external trigger pin start; the code applies the trigger setting in one-shot mode only.
// [R09] One-shot software start converts the one selected channel of eight.
// [R10] One-shot end: load result, set request, clear start, halt.
// [R11] Trigger mode with start set: falling trigger edge starts conversion.
// [R12] Trigger conversion end: store, set request, stop, await next edge.
// [R13] Trigger edge during conversion aborts and restarts it.
// [R14] Expanded input: convert chosen expansion input, finish as one-shot.
// [R15] Amplifier mode: route channel out, convert expansion input pin.
// [R16] Repeat mode converts continuously, no interrupt request.
// [R17] Repeat continues until software clears the start flag.
// [R18] Sweep group is channels 0-1, 0-3, 0-5 or 0-7.
// [R19] Software waits 1 us after reference reconnect before starting.
// [R20] Sweep converts each channel in turn, then request and stop.
// [R21] Approximation resolves bits MSB first from midscale.
// [R22] Clearing start mid-conversion abandons it without writing results.
package sar_adc_pkg;
  localparam int RES_BITS = 10;
  localparam int CHANNELS = 8;
  localparam logic [5:0] CYC_SH_10 = 6'd33;
  localparam logic [5:0] CYC_SH_8 = 6'd28;
  localparam logic [5:0] CYC_NS_10 = 6'd59;
  localparam logic [5:0] CYC_NS_8 = 6'd49;
  localparam logic [5:0] SAMPLE_CYC = 6'd3;
  localparam logic [9:0] MIDSCALE = 10'h200;
  localparam logic [3:0] BITS_10 = 4'ha;
  localparam logic [3:0] BITS_8 = 4'h8;
  // Clock select codes
  localparam logic [1:0] DIV_4 = 2'h0;
  localparam logic [1:0] DIV_2 = 2'h1;
  localparam logic [1:0] DIV_1 = 2'h2;
  typedef enum logic [1:0] {
    MODE_ONE_SHOT, MODE_REPEAT, MODE_SWEEP
  } mode_e;
  typedef enum logic [1:0] {
    INPUT_NORMAL, INPUT_EXPANDED, INPUT_AMPLIFIER
  } route_e;
endpackage : sar_adc_pkg

// file: rtl/sar_adc_sequencer.sv
`timescale 1ns/1ps
module sar_adc_sequencer (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Control bits
  input wire logic start_set,
  input wire logic start_clear,
  input wire sar_adc_pkg::mode_e mode,
  input wire sar_adc_pkg::route_e route,
  input wire logic [1:0] clock_select,
  input wire logic resolution_10,
  input wire logic sample_hold_en,
  input wire logic trigger_select,
  input wire logic [2:0] channel_select,
  input wire logic [1:0] sweep_group,
  input wire logic expansion_select,
  input wire logic request_clear,
  // Pins and analog side
  input wire logic conv_trigger_pin,
  input wire logic comparator_high,
  // Status and results
  output logic start_flag,
  output logic conv_request,
  output logic busy,
  output logic [2:0] analog_input_channel,
  output logic selected_expansion_input,
  output logic expansion_out_pin,
  output wire logic [9:0] trial_code,
  output logic [9:0] result [8],
  output logic [7:0] result_strobe
);
  import sar_adc_pkg::*;

  // ****************************************************
  // Reset and pin synchronisers
  // ****************************************************
  logic rst_meta, rst_n;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  logic trig_meta, trig_sync, trig_prev;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trig_meta <= 1'b1;
      trig_sync <= 1'b1;
      trig_prev <= 1'b1;
    end else begin
      trig_meta <= conv_trigger_pin;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
    end
  end
  logic trig_fall;
  assign trig_fall = trig_prev & ~trig_sync;

  logic cmp_meta, cmp_sync;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= comparator_high;
      cmp_sync <= cmp_meta;
    end
  end

  // ****************************************************
  // Conversion clock enable
  // ****************************************************
  logic [1:0] div_count;
  logic tick;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) div_count <= 2'h0;
    else div_count <= div_count + 2'h1;
  end
  // [R04] Divider select
  always_comb begin
    case (clock_select)
      DIV_4: tick = (div_count == 2'h3);
      DIV_2: tick = div_count[0];
      default: tick = 1'b1;
    endcase
  end

  // ****************************************************
  // Sequencer
  // ****************************************************
  typedef enum logic [1:0] {IDLE, WAIT_TRIG, SAMPLE, CONVERT} state_e;
  state_e state;
  logic [5:0] cycle;
  logic [3:0] bit_idx;
  logic [9:0] sar;
  logic [2:0] chan;
  logic [2:0] last_chan;
  logic [5:0] total_cyc;
  logic [3:0] nbits;

  // [R01] [R02] Cycles per channel
  function automatic logic [5:0] cycles_for(input logic sh,
                                            input logic r10);
    if (sh) cycles_for = r10 ? CYC_SH_10 : CYC_SH_8;
    else cycles_for = r10 ? CYC_NS_10 : CYC_NS_8;
  endfunction : cycles_for

  assign total_cyc = cycles_for(sample_hold_en, resolution_10);
  // [R07] Eight-bit resolves top bits only
  assign nbits = resolution_10 ? BITS_10 : BITS_8;
  // [R18] Sweep group top channel
  assign last_chan = {sweep_group, 1'b1};

  // Bit decisions are spread evenly after the sampling window
  // Each lands one tick early so the last bit is in before the write
  logic [5:0] bit_period;
  assign bit_period = 6'((total_cyc - SAMPLE_CYC) / {2'h0, nbits});

  logic last_cycle, stop_now, trig_mode;
  assign last_cycle = tick && (cycle == total_cyc - 6'd1);
  assign stop_now = start_clear;
  assign trig_mode = trigger_select && (mode == MODE_ONE_SHOT);

  logic finish, finish_last;
  assign finish = (state == CONVERT) && last_cycle && !stop_now
                  && !(trig_mode && trig_fall);
  assign finish_last = (mode == MODE_SWEEP) ? (chan == last_chan)
                                             : 1'b1;

  // [R08] [R09] [R11] [R13] [R17] [R22] State control
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE;
      cycle <= 6'h0;
      chan <= 3'h0;
    end else if (stop_now || (state != IDLE && !start_flag)) begin
      state <= IDLE;
      cycle <= 6'h0;
    end else begin
      case (state)
        IDLE: begin
          cycle <= 6'h0;
          chan <= (mode == MODE_SWEEP) ? 3'h0 : channel_select;
          if (start_set) state <= trig_mode ? WAIT_TRIG : SAMPLE;
        end
        WAIT_TRIG: begin
          cycle <= 6'h0;
          chan <= channel_select;
          if (trig_fall) state <= SAMPLE;
        end
        SAMPLE, CONVERT: begin
          if (trig_mode && trig_fall) begin
            state <= SAMPLE;
            cycle <= 6'h0;
          end else if (last_cycle) begin
            cycle <= 6'h0;
            state <= SAMPLE;
            // [R03] Next channel restarts the count
            if (mode == MODE_SWEEP) begin
              if (finish_last) state <= IDLE;
              else chan <= chan + 3'h1;
            end else if (mode == MODE_ONE_SHOT) begin
              state <= trig_mode ? WAIT_TRIG : IDLE;
            end
          end else if (tick) begin
            cycle <= cycle + 6'h1;
            // [R05] Sampling window
            if (cycle == SAMPLE_CYC - 6'd1) state <= CONVERT;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // [R21] Successive approximation from midscale
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sar <= MIDSCALE;
      bit_idx <= 4'h0;
    end else if (state != CONVERT) begin
      sar <= MIDSCALE;
      bit_idx <= 4'h0;
    end else if (tick && bit_idx < nbits && bit_period != 6'h0
                 && 6'(cycle - SAMPLE_CYC + 6'd2) ==
                    6'(bit_period * {2'h0, bit_idx + 4'h1})) begin
      sar[4'd9 - bit_idx] <= cmp_sync;
      if (bit_idx + 4'h1 < nbits)
        sar[4'd8 - bit_idx] <= 1'b1;
      bit_idx <= bit_idx + 4'h1;
    end
  end

  // ****************************************************
  // Start flag and request
  // ****************************************************
  // [R10] [R14] [R20] Start flag clears at the end of a pass
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) start_flag <= 1'b0;
    else if (start_set) start_flag <= 1'b1;
    else if (start_clear) start_flag <= 1'b0;
    else if (finish && finish_last && !trig_mode
             && mode != MODE_REPEAT)
      start_flag <= 1'b0;
  end

  // [R10] [R12] [R16] Request set wins over clear, never in repeat
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) conv_request <= 1'b0;
    else if (finish && finish_last && mode != MODE_REPEAT)
      conv_request <= 1'b1;
    else if (request_clear) conv_request <= 1'b0;
  end

  // ****************************************************
  // Results and routing
  // ****************************************************
  // [R10] [R15] [R16] Result written only on a full conversion
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANNELS; i++) result[i] <= 10'h0;
      result_strobe <= 8'h0;
    end else begin
      result_strobe <= 8'h0;
      if (finish) begin
        result[chan] <= resolution_10 ? sar : {2'h0, sar[9:2]};
        result_strobe[chan] <= 1'b1;
      end
    end
  end

  // Busy while sampling or converting
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) busy <= 1'b0;
    else busy <= (state == SAMPLE) || (state == CONVERT);
  end

  // Channel currently routed to the converter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) analog_input_channel <= 3'h0;
    else analog_input_channel <= chan;
  end

  // [R14] Expansion input choice
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) selected_expansion_input <= 1'b0;
    else selected_expansion_input <= (route == INPUT_AMPLIFIER)
                                     ? 1'b1 : expansion_select;
  end

  // [R15] Amplifier routing out
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) expansion_out_pin <= 1'b0;
    else expansion_out_pin <= (route == INPUT_AMPLIFIER)
                              && (state != IDLE);
  end

  // Trial code comes straight from the approximation register so the
  // comparator answer is back through its synchroniser in time
  assign trial_code = sar;
endmodule : sar_adc_sequencer

// file: verif/analog_side.sv
`timescale 1ns/1ps
module analog_side (
  // Clock and design side
  input wire logic clock,
  input wire logic busy,
  input wire logic [9:0] trial_code,
  // Bench controls
  input wire logic [9:0] level,
  input wire logic fire,
  // Pins
  output logic comparator_high,
  output logic conv_trigger_pin
);
  initial conv_trigger_pin = 1'b1;
  // Ideal comparator on the live trial code
  assign comparator_high = busy && (level >= trial_code);
  always @(posedge clock) conv_trigger_pin <= ~fire;
endmodule : analog_side

// file: verif/sar_adc_sequencer_asserts.sv
`timescale 1ns/1ps
module sar_adc_sequencer_asserts
  import sar_adc_pkg::*;
(
  // Clock and controls
  input wire logic clock,
  input wire logic arst_n,
  input wire logic start_set,
  input wire logic start_clear,
  input wire sar_adc_pkg::mode_e mode,
  input wire sar_adc_pkg::route_e route,
  input wire logic trigger_select,
  // Status
  input wire logic start_flag,
  input wire logic conv_request,
  input wire logic busy,
  input wire logic expansion_out_pin,
  input wire logic [7:0] result_strobe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  strobe_onehot_a: assert property ($onehot0(result_strobe))
    else $error("strobes overlap");
  strobe_in_run_a: assert property (|result_strobe |-> $past(busy))
    else $error("strobe while idle");
  set_raises_a: assert property (start_set |=> start_flag)
    else $error("start flag not set");
  clear_drops_a: assert property (start_clear && !start_set |=>
    !start_flag) else $error("start flag not cleared");
  clear_no_write_a: assert property (start_clear && !start_set |=>
    ##1 (result_strobe == 8'h0) [*3]) else $error("write after clear");
  req_with_write_a: assert property ($rose(conv_request) |->
    |result_strobe) else $error("request without result");
  repeat_no_req_a: assert property (mode == MODE_REPEAT &&
    !conv_request |=> !conv_request) else $error("request in repeat");
  trig_keeps_flag_a: assert property (trigger_select &&
    $rose(conv_request) |-> start_flag) else $error("flag lost");
  oneshot_clears_a: assert property (!trigger_select &&
    mode == MODE_ONE_SHOT && $rose(conv_request) |-> !start_flag)
    else $error("flag kept");
  amp_route_a: assert property (busy && $past(busy) &&
    route == INPUT_AMPLIFIER |-> expansion_out_pin)
    else $error("no amplifier routing");
  cover property (result_strobe[7]);
  cover property (trigger_select && $rose(conv_request));
  cover property (mode == MODE_REPEAT && |result_strobe);
endmodule : sar_adc_sequencer_asserts

// file: verif/tb_sar_adc_sequencer.sv
`timescale 1ns/1ps
module tb_sar_adc_sequencer;
  import sar_adc_pkg::*;
  logic clock = 0, arst_n = 0, start_set = 0, start_clear = 0, fire = 0;
  logic resolution_10 = 0, sample_hold_en = 0, trigger_select = 0;
  logic request_clear = 0, expansion_select = 0;
  logic [1:0] clock_select = 0, sweep_group = 0;
  logic [2:0] channel_select = 0, analog_input_channel;
  logic [9:0] level = 0, trial_code, result [8];
  logic [7:0] result_strobe;
  logic conv_trigger_pin, comparator_high, start_flag, conv_request, busy;
  logic selected_expansion_input, expansion_out_pin;
  mode_e mode = MODE_ONE_SHOT;
  route_e route = INPUT_NORMAL;
  int checks = 0, num_errors = 0, cyc = 0, ch, t, n, d, s;
  always #25 clock = ~clock;
  always @(posedge clock) cyc++;
  sar_adc_sequencer i_sar_adc_sequencer (.clock, .arst_n, .start_set,
    .start_clear, .mode, .route, .clock_select, .resolution_10,
    .sample_hold_en, .trigger_select, .channel_select, .sweep_group,
    .expansion_select, .request_clear, .conv_trigger_pin, .comparator_high,
    .start_flag, .conv_request, .busy, .analog_input_channel,
    .selected_expansion_input, .expansion_out_pin, .trial_code, .result,
    .result_strobe);
  analog_side i_analog_side (.clock, .busy, .trial_code, .level, .fire,
    .comparator_high, .conv_trigger_pin);
  task automatic results;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    @(negedge clock);
    sig = 1'b0;
  endtask : pulse
  task automatic wait_strobe;
    ch = -1;
    for (int i = 0; i < 9000 && ch < 0; i++) begin
      @(negedge clock);
      for (int k = 0; k < 8; k++) if (result_strobe[k] === 1'b1) ch = k;
    end
    if (ch < 0) begin
      num_errors++;
      results();
    end
  endtask : wait_strobe
  // Per-channel ticks and divider of the current setting
  task automatic load_cfg;
    n = sample_hold_en ? (resolution_10 ? 33 : 28)
                       : (resolution_10 ? 59 : 49);
    d = clock_select == 2'h0 ? 4 : clock_select == 2'h1 ? 2 : 1;
    level = 10'($urandom);
    @(negedge clock);
  endtask : load_cfg
  function automatic logic [9:0] exp_val;
    return resolution_10 ? level : {2'h0, level[9:2]};
  endfunction : exp_val
  task automatic done(logic f);
    chk("req", 10'h1, 10'(conv_request));
    chk("flag", 10'(f), 10'(start_flag));
    pulse(request_clear);
    chk("req_clr", 10'h0, 10'(conv_request));
  endtask : done
  initial begin
    void'($urandom(60));
    repeat (6) @(negedge clock);
    arst_n = 1;
    repeat (25) @(negedge clock);
    mode = MODE_SWEEP;
    for (int j = 0; j < 4; j++) begin
      {resolution_10, sample_hold_en} = 2'(j);
      clock_select = 2'(j);
      sweep_group = 2'(j);
      load_cfg();
      pulse(start_set);
      for (int k = 0; k <= 2 * j + 1; k++) begin
        wait_strobe();
        chk("chan", 10'(k), 10'(ch));
        chk("data", exp_val(), result[k]);
        if (k > 0)
          chk("gap", 10'(n * d), 10'(cyc - t));
        t = cyc;
      end
      done(1'b0);
    end
    mode = MODE_ONE_SHOT;
    for (int r = 0; r < 3; r++) begin
      route = route_e'(2'(r));
      channel_select = 3'(r + 5);
      expansion_select = r[0];
      load_cfg();
      pulse(start_set);
      wait_strobe();
      if (r != 1) chk("chan", 10'(r + 5), 10'(ch));
      chk("ain", 10'(r + 5), 10'(analog_input_channel));
      chk("exp_in", 10'(r != 0), 10'(selected_expansion_input));
      chk("exp_out", 10'(r == 2), 10'(expansion_out_pin));
      chk("data", exp_val(), result[ch]);
      done(1'b0);
    end
    mode = MODE_REPEAT;
    route = INPUT_NORMAL;
    channel_select = 3'h3;
    load_cfg();
    pulse(start_set);
    for (int k = 0; k < 3; k++) begin
      wait_strobe();
      chk("rep", exp_val(), result[3]);
    end
    repeat (9) @(negedge clock);
    pulse(start_clear);
    s = 0;
    repeat (300) begin
      @(negedge clock);
      s += int'(result_strobe !== 8'h0);
    end
    chk("halt", 10'h0, {busy, conv_request, start_flag, 7'(s)});
    mode = MODE_ONE_SHOT;
    trigger_select = 1;
    channel_select = 3'h2;
    load_cfg();
    pulse(start_set);
    for (int k = 0; k < 2; k++) begin
      repeat (5) @(negedge clock);
      pulse(fire);
      if (k == 0) begin
        repeat (20) @(negedge clock);
        pulse(fire);
      end
      t = cyc;
      wait_strobe();
      chk("restart", 10'h1, 10'(cyc - t >= n * d));
      chk("data", exp_val(), result[2]);
      done(1'b1);
    end
    pulse(start_clear);
    results();
  end
endmodule : tb_sar_adc_sequencer
bind sar_adc_sequencer sar_adc_sequencer_asserts i_sar_adc_sequencer_asserts (
  .clock, .arst_n, .start_set, .start_clear, .mode, .route,
  .trigger_select, .start_flag, .conv_request, .busy, .expansion_out_pin,
  .result_strobe);
